// >>> core/srfc_top.v
// supply ripple rejection control, coefficient and measurement registers
// Functional notes
// - rejection reset output stays low while its config bit is 0 (default).
// - internal feedback logic runs only while feedback enable bit is 1.
// - sync clock divides the crystal clock; divider code 000 disables it.
// - codes 001 to 110 divide by 32, 64, 128, 256, 512, 1024.
// - coefficient is scale times two to the shift; shift resets to 010.
// - scale is 19-bit signed 1.18, reset value 25868h.
// - coefficient is applied to the measured supply reading for calibration.
// - shift and scale top bits at 35h; middle and low scale bytes follow.
// - read-only supply measurement is updated continuously from the circuit.
// - measurement is 24-bit signed 2.22, reset 000000h.
// - measurement bytes: most significant at 3Bh, least at 3Dh.
// - rejection enable bit drives its output pin directly.
`timescale 1ns/100ps
`default_nettype none
`include "srfc_defs.vh"

module srfc_top (
    input  wire                      mclk_i,
    input  wire                      rst_i,
    input  wire                      ce_i,
    // control port register access
    input  wire [7:0]                reg_addr_i,
    input  wire [7:0]                reg_wdata_i,
    input  wire                      reg_wr_i,
    input  wire                      reg_rd_i,
    output wire [7:0]                reg_rdata_o,
    output wire                      reg_rvalid_o,
    // external feedback circuit
    input  wire [`SRFC_MEAS_W-1:0]   meas_data_i,
    input  wire                      meas_strobe_i,
    output wire                      rejection_circuit_reset_n_o,
    output wire                      rejection_output_enable_o,
    output wire                      supply_sync_clock_o,
    // corrected reading for the internal feedback path
    output wire [`SRFC_MEAS_W-1:0]   feedback_value_o,
    output wire                      feedback_valid_o,
    output wire                      feedback_enable_o
);

    // product of a 2.22 reading by a 1.18 scale, plus room for the largest shift of seven
    localparam PROD_W = `SRFC_MEAS_W + `SRFC_SCALE_W;
    localparam WIDE_W = PROD_W + 7;

    reg  [7:0]                    cfg_reg;
    reg  [`SRFC_SHIFT_W-1:0]      shift_reg;
    reg  [`SRFC_SCALE_W-1:0]      scale_reg;
    reg  [`SRFC_MEAS_W-1:0]       meas_reg;
    reg  [`SRFC_MEAS_W-1:0]       meas_s1_reg;
    reg  [`SRFC_MEAS_W-1:0]       meas_s2_reg;
    reg                           stb_s1_reg;
    reg                           stb_s2_reg;
    reg                           stb_d_reg;
    reg                           calc_go_reg;
    reg  [`SRFC_MEAS_W-1:0]       fb_value_reg;
    reg                           fb_valid_reg;
    reg  [7:0]                    rdata_reg;
    reg                           rvalid_reg;
    reg  [7:0]                    rdata_next;
    wire                          stb_rise;
    wire                          fb_en;
    wire signed [WIDE_W-1:0]      wide_prod;
    wire [`SRFC_MEAS_W-1:0]       corrected;
    wire                          wr_cfg;
    wire                          wr_coef_hi;
    wire                          wr_coef_mid;
    wire                          wr_coef_lo;

    // saturate a wide signed value to the 24-bit measurement format
    function [`SRFC_MEAS_W-1:0] sat24;
        input signed [WIDE_W-1:0] v;
        begin
            if (v > $signed({{(WIDE_W-`SRFC_MEAS_W+1){1'b0}}, {(`SRFC_MEAS_W-1){1'b1}}}))
                sat24 = {1'b0, {(`SRFC_MEAS_W-1){1'b1}}};
            else if (v < $signed({{(WIDE_W-`SRFC_MEAS_W+1){1'b1}}, {(`SRFC_MEAS_W-1){1'b0}}}))
                sat24 = {1'b1, {(`SRFC_MEAS_W-1){1'b0}}};
            else
                sat24 = v[`SRFC_MEAS_W-1:0];
        end
    endfunction

    // decode a control-port address against one register offset
    function hit;
        input [7:0] addr;
        input [7:0] offs;
        begin
            hit = (addr == offs);
        end
    endfunction

    assign fb_en = cfg_reg[`SRFC_CFG_FB_EN_BIT];

    // one write strobe per writable offset; frozen cycles take no write
    assign wr_cfg      = ce_i & reg_wr_i & hit(reg_addr_i, `SRFC_ADDR_CONFIG);
    assign wr_coef_hi  = ce_i & reg_wr_i & hit(reg_addr_i, `SRFC_ADDR_COEF_HI);
    assign wr_coef_mid = ce_i & reg_wr_i & hit(reg_addr_i, `SRFC_ADDR_COEF_MID);
    assign wr_coef_lo  = ce_i & reg_wr_i & hit(reg_addr_i, `SRFC_ADDR_COEF_LO);

    // register writes
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg   <= `SRFC_CFG_RESET;
            shift_reg <= `SRFC_SHIFT_RESET;
            scale_reg <= `SRFC_SCALE_RESET;
        end else begin
            if (wr_cfg)
                cfg_reg <= reg_wdata_i & `SRFC_CFG_WMASK;
            if (wr_coef_hi) begin
                shift_reg <= reg_wdata_i[`SRFC_SHIFT_MSB:`SRFC_SHIFT_LSB];
                scale_reg[`SRFC_SCALE_W-1:16] <=
                    reg_wdata_i[`SRFC_SCALE_TOP_MSB:`SRFC_SCALE_TOP_LSB];
            end
            if (wr_coef_mid)
                scale_reg[15:8] <= reg_wdata_i;
            if (wr_coef_lo)
                scale_reg[7:0] <= reg_wdata_i;
            // measurement offsets take no write path at all
        end
    end

    // measurement pins pass two flops before use
    // the data bus is sampled bit by bit; the far side holds it steady around the strobe
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meas_s1_reg <= `SRFC_MEAS_RESET;
            meas_s2_reg <= `SRFC_MEAS_RESET;
            stb_s1_reg  <= 1'b0;
            stb_s2_reg  <= 1'b0;
            stb_d_reg   <= 1'b0;
        end else if (ce_i) begin
            meas_s1_reg <= meas_data_i;
            meas_s2_reg <= meas_s1_reg;
            stb_s1_reg  <= meas_strobe_i;
            stb_s2_reg  <= stb_s1_reg;
            stb_d_reg   <= stb_s2_reg;
        end
    end

    assign stb_rise = stb_s2_reg & ~stb_d_reg;

    // live measurement, refreshed on every strobe regardless of other state
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meas_reg <= `SRFC_MEAS_RESET;
        end else if (ce_i && stb_rise) begin
            meas_reg <= meas_s2_reg;
        end
    end

    // coefficient applied: meas * scale * 2^shift, back to 2.22
    assign wide_prod = ($signed({{7{meas_reg[`SRFC_MEAS_W-1]}}, meas_reg})
                        * $signed({{(WIDE_W-`SRFC_SCALE_W){scale_reg[`SRFC_SCALE_W-1]}},
                                   scale_reg})) <<< shift_reg;
    assign corrected = sat24(wide_prod >>> `SRFC_SCALE_FRAC);

    // feedback path runs one cycle after each new measurement when enabled
    // a disabled path reads zero so nothing stale is fed back
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            calc_go_reg  <= 1'b0;
            fb_value_reg <= `SRFC_MEAS_RESET;
            fb_valid_reg <= 1'b0;
        end else if (ce_i) begin
            calc_go_reg  <= stb_rise & fb_en;
            fb_valid_reg <= calc_go_reg & fb_en;
            if (!fb_en)
                fb_value_reg <= `SRFC_MEAS_RESET;
            else if (calc_go_reg)
                fb_value_reg <= corrected;
        end
    end

    // register read mux; reserved and unmapped bits read as zero
    // measurement bytes are read one at a time; a strobe between reads can tear them
    always @* begin
        rdata_next = 8'h00;
        case (reg_addr_i)
            `SRFC_ADDR_CONFIG:   rdata_next = cfg_reg;
            `SRFC_ADDR_COEF_HI:  rdata_next = {1'b0, shift_reg, 1'b0,
                                               scale_reg[`SRFC_SCALE_W-1:16]};
            `SRFC_ADDR_COEF_MID: rdata_next = scale_reg[15:8];
            `SRFC_ADDR_COEF_LO:  rdata_next = scale_reg[7:0];
            `SRFC_ADDR_MEAS_HI:  rdata_next = meas_reg[23:16];
            `SRFC_ADDR_MEAS_MID: rdata_next = meas_reg[15:8];
            `SRFC_ADDR_MEAS_LO:  rdata_next = meas_reg[7:0];
            default:             rdata_next = 8'h00;
        endcase
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end else if (ce_i) begin
            rvalid_reg <= reg_rd_i;
            // read data is captured only on a read so it holds between reads
            if (reg_rd_i)
                rdata_reg <= rdata_next;
        end
    end

    srfc_sync_div u_sync_div (
        .mclk_i     (mclk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .div_code_i (cfg_reg[`SRFC_CFG_DIV_MSB:`SRFC_CFG_DIV_LSB]),
        .sync_clk_o (supply_sync_clock_o)
    );

    assign rejection_circuit_reset_n_o = cfg_reg[`SRFC_CFG_RST_BIT];
    assign rejection_output_enable_o   = cfg_reg[`SRFC_CFG_OUT_EN_BIT];
    assign feedback_enable_o           = fb_en;
    assign feedback_value_o            = fb_value_reg;
    assign feedback_valid_o            = fb_valid_reg;
    assign reg_rdata_o                 = rdata_reg;
    assign reg_rvalid_o                = rvalid_reg;

endmodule // srfc_top

`default_nettype wire

// >>> core/srfc_defs.vh
// register map, field positions and reset values of the supply ripple feedback control block
`ifndef SRFC_DEFS_VH
`define SRFC_DEFS_VH

// register offsets on the control port
`define SRFC_ADDR_CONFIG        8'h34
`define SRFC_ADDR_COEF_HI       8'h35
`define SRFC_ADDR_COEF_MID      8'h36
`define SRFC_ADDR_COEF_LO       8'h37
`define SRFC_ADDR_MEAS_HI       8'h3b
`define SRFC_ADDR_MEAS_MID      8'h3c
`define SRFC_ADDR_MEAS_LO       8'h3d

// ripple_reject_config fields
`define SRFC_CFG_OUT_EN_BIT     7
`define SRFC_CFG_RST_BIT        6
`define SRFC_CFG_FB_EN_BIT      5
`define SRFC_CFG_DIV_MSB        2
`define SRFC_CFG_DIV_LSB        0
`define SRFC_CFG_WMASK          8'he7
`define SRFC_CFG_RESET          8'h00

// decim_coef_hi fields
`define SRFC_SHIFT_MSB          6
`define SRFC_SHIFT_LSB          4
`define SRFC_SCALE_TOP_MSB      2
`define SRFC_SCALE_TOP_LSB      0

// coefficient and measurement formats
`define SRFC_SHIFT_W            3
`define SRFC_SCALE_W            19
`define SRFC_SCALE_FRAC         18
`define SRFC_MEAS_W             24
`define SRFC_SHIFT_RESET        3'h2
`define SRFC_SCALE_RESET        19'h25868
`define SRFC_MEAS_RESET         24'h000000

// divider codes and ratios
`define SRFC_DIV_W              3
`define SRFC_DIV_OFF            3'h0
`define SRFC_DIV_MAX_CODE       3'h6
`define SRFC_DIV_BASE_LOG2      5
`define SRFC_DIV_CNT_W          10

`endif

// >>> core/srfc_sync_div.v
// supply synchronisation clock divider from the crystal clock
`timescale 1ns/100ps
`default_nettype none
`include "srfc_defs.vh"

module srfc_sync_div (
    input  wire                      mclk_i,
    input  wire                      rst_i,
    input  wire                      ce_i,
    input  wire [`SRFC_DIV_W-1:0]    div_code_i,
    output wire                      sync_clk_o
);

    reg  [`SRFC_DIV_CNT_W-1:0] cnt_reg;
    reg  [`SRFC_DIV_CNT_W-1:0] cnt_next;
    reg                        clk_reg;
    reg                        clk_next;
    reg  [`SRFC_DIV_W-1:0]     code_reg;
    wire                       active;
    wire [`SRFC_DIV_CNT_W-1:0] half_last;

    // codes 001..110 divide by 32..1024; 000 and the spare code stop the clock
    assign active = (div_code_i != `SRFC_DIV_OFF) && (div_code_i <= `SRFC_DIV_MAX_CODE);
    // half period minus one: 16<<(code-1) - 1
    assign half_last = ({{(`SRFC_DIV_CNT_W-1){1'b0}}, 1'b1}
                        << (`SRFC_DIV_BASE_LOG2 - 1 + div_code_i - 1)) - 1'b1;

    always @* begin
        cnt_next = cnt_reg;
        clk_next = clk_reg;
        if (!active || (div_code_i != code_reg)) begin
            cnt_next = {`SRFC_DIV_CNT_W{1'b0}};
            clk_next = 1'b0;
        end else if (cnt_reg >= half_last) begin
            cnt_next = {`SRFC_DIV_CNT_W{1'b0}};
            clk_next = ~clk_reg;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg  <= {`SRFC_DIV_CNT_W{1'b0}};
            clk_reg  <= 1'b0;
            code_reg <= `SRFC_DIV_OFF;
        end else if (ce_i) begin
            cnt_reg  <= cnt_next;
            clk_reg  <= clk_next;
            code_reg <= div_code_i;
        end
    end

    assign sync_clk_o = clk_reg;

endmodule // srfc_sync_div

`default_nettype wire

// >>> sim/srfc_asserts.sv
// assertion checker for the supply ripple feedback control block
`timescale 1ns/100ps
`default_nettype none
module srfc_asserts (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic        reg_rvalid_o,
    input wire logic        meas_strobe_i,
    input wire logic        rejection_circuit_reset_n_o,
    input wire logic        rejection_output_enable_o,
    input wire logic        supply_sync_clock_o,
    input wire logic [23:0] feedback_value_o,
    input wire logic        feedback_valid_o,
    input wire logic        feedback_enable_o
);
    logic        cfg_wr;
    logic [7:0]  cfg_q;
    logic [10:0] cnt_q;
    logic        seen_q;
    logic        sync_q;
    assign cfg_wr = ce_i && reg_wr_i && reg_addr_i == 8'h34;
    // cycles since the last sync rise, restarted at each rise; a config write clears seen_q instead
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_q <= 8'h00;
            cnt_q <= 11'h0;
            seen_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            sync_q <= supply_sync_clock_o;
            cnt_q <= cnt_q + 11'h1;
            if (cfg_wr) begin
                cfg_q <= reg_wdata_i;
                seen_q <= 1'b0;
            end else if (supply_sync_clock_o && !sync_q) begin
                seen_q <= 1'b1;
                cnt_q <= 11'h1;
            end
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    a_reset_pin_follows: assert property (cfg_wr |=>
        rejection_circuit_reset_n_o == $past(reg_wdata_i[6])) else $error("reset pin wrong");
    a_enable_pin_follows: assert property (cfg_wr |=>
        rejection_output_enable_o == $past(reg_wdata_i[7])) else $error("enable pin wrong");
    a_feedback_bit_follows: assert property (cfg_wr |=>
        feedback_enable_o == $past(reg_wdata_i[5])) else $error("feedback bit wrong");
    a_feedback_off_quiet: assert property (!feedback_enable_o && !$past(feedback_enable_o)
        |-> feedback_value_o == 24'h0 && !feedback_valid_o) else $error("feedback active");
    a_sync_off_low: assert property (cfg_q[2:0] == 3'h0 && $past(cfg_q[2:0]) == 3'h0
        |-> !supply_sync_clock_o) else $error("sync clock runs");
    a_sync_period_exact: assert property ($rose(supply_sync_clock_o) && seen_q
        |-> cnt_q == 11'd32 << (cfg_q[2:0] - 3'd1)) else $error("sync period wrong");
    a_read_answer: assert property (reg_rd_i && ce_i |=> reg_rvalid_o)
        else $error("read not answered");
    a_no_stray_valid: assert property (!reg_rd_i && ce_i |=> !reg_rvalid_o)
        else $error("stray read valid");
    a_feedback_latency: assert property ($rose(meas_strobe_i) && feedback_enable_o
        |-> ##[4:6] feedback_valid_o) else $error("feedback late");
endmodule // srfc_asserts
bind srfc_top srfc_asserts srfc_asserts_inst (.*);
`default_nettype wire

// >>> sim/srfc_supply_model.sv
// behavioural model of the external supply feedback circuit
`timescale 1ns/100ps
`default_nettype none
module srfc_supply_model (
    input  wire logic        mclk_i,
    output logic [23:0]      meas_data_o,
    output logic             meas_strobe_o
);
    initial begin
        meas_data_o = 24'h5a5a5a;
        meas_strobe_o = 1'b0;
    end
    // data leads the strobe by a cycle and is held well past the load
    task automatic send(input logic [23:0] d);
        @(negedge mclk_i);
        meas_data_o = d;
        @(negedge mclk_i);
        meas_strobe_o = 1'b1;
        repeat (5) @(negedge mclk_i);
        meas_strobe_o = 1'b0;
        meas_data_o = ~d;
        repeat (4) @(negedge mclk_i);
    endtask
endmodule // srfc_supply_model
`default_nettype wire

// >>> sim/supply_ripple_feedback_ctrl_tb_top.sv
// self-checking bench for the supply ripple feedback control block
`timescale 1ns/100ps
`default_nettype none
module supply_ripple_feedback_ctrl_tb_top;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  rdata;
    logic        rvalid, rst_n, out_en, sync, fb_valid, fb_en, strobe;
    logic [23:0] meas, fb_value;
    logic [31:0] seed = 32'h18d5;
    logic [7:0]  ra [8] = '{8'h34, 8'h35, 8'h36, 8'h37, 8'h3b, 8'h3c, 8'h3d, 8'h40};
    logic [7:0]  rv [8] = '{8'h00, 8'h22, 8'h58, 8'h68, 8'h00, 8'h00, 8'h00, 8'h00};
    int          failures = 0;
    int          num_checks = 0;
    always #25 mclk_i = ~mclk_i;
    srfc_top srfc_top_inst (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .meas_data_i(meas), .meas_strobe_i(strobe),
        .rejection_circuit_reset_n_o(rst_n), .rejection_output_enable_o(out_en),
        .supply_sync_clock_o(sync), .feedback_value_o(fb_value),
        .feedback_valid_o(fb_valid), .feedback_enable_o(fb_en));
    srfc_supply_model srfc_supply_model_inst (.mclk_i(mclk_i), .meas_data_o(meas),
        .meas_strobe_o(strobe));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [23:0] exp_fb(logic [23:0] d, logic [18:0] s, logic [2:0] sh);
        longint p;
        p = (longint'($signed(d)) * $signed(s)) <<< sh >>> 18;
        return p > 64'sh7fffff ? 24'h7fffff : p < -64'sh800000 ? 24'h800000 : p[23:0];
    endfunction
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk_i);
        wr = 1'b0;
        @(negedge mclk_i);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        rd = 1'b1;
        @(negedge mclk_i);
        rd = 1'b0;
        chk({15'h0, rvalid, rdata}, {16'h1, e});
        @(negedge mclk_i);
    endtask
    task automatic to_rise(output int n);
        n = 0;
        while (sync === 1'b1 && n < 2100) begin
            @(negedge mclk_i);
            n++;
        end
        while (sync !== 1'b1 && n < 2100) begin
            @(negedge mclk_i);
            n++;
        end
    endtask
    task automatic wait_fb(input logic on, input logic [23:0] e);
        int n = 0;
        while (fb_valid !== 1'b1 && n < 30) begin
            @(negedge mclk_i);
            n++;
        end
        chk({23'h0, n < 30}, {23'h0, on});
        chk(fb_value, e);
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #(40000 * 50);
        failures++;
        conclude();
    end
    initial begin
        logic [31:0] v;
        logic [31:0] x;
        int n;
        repeat (4) @(negedge mclk_i);
        rst_i = 1'b0;
        @(negedge mclk_i);
        chk({20'h0, rst_n, out_en, fb_en, sync}, 24'h0);
        for (int i = 0; i < 8; i++) rd_chk(ra[i], rv[i]);
        ce = 1'b0;
        wr_reg(8'h34, 8'hff);
        ce = 1'b1;
        chk({20'h0, rst_n, out_en, fb_en, sync}, 24'h0);
        rd_chk(8'h34, 8'h00);
        $display("test reset values done");
        repeat (6) begin
            v = rnd();
            wr_reg(8'h34, v[7:0]);
            chk({21'h0, out_en, rst_n, fb_en}, {21'h0, v[7:5]});
            rd_chk(8'h34, v[7:0] & 8'he7);
        end
        $display("test config done");
        for (int k = 1; k < 7; k++) begin
            wr_reg(8'h34, 8'h40 | k[7:0]);
            to_rise(n);
            to_rise(n);
            chk(24'(n), 24'd32 << (k - 1));
        end
        for (int c = 0; c < 8; c += 7) begin
            wr_reg(8'h34, 8'h40 | c[7:0]);
            to_rise(n);
            chk(24'(n), 24'd2100);
        end
        $display("test sync divider done");
        for (int i = 0; i < 5; i++) begin
            v = i == 0 ? 32'h12 : i == 1 ? 32'hffff73 : rnd();
            x = i == 0 ? 32'h400000 : i == 1 ? 32'h7fffff : rnd();
            wr_reg(8'h34, i == 4 ? 8'h40 : 8'h60);
            wr_reg(8'h35, v[7:0]);
            wr_reg(8'h36, v[15:8]);
            wr_reg(8'h37, v[23:16]);
            rd_chk(8'h35, v[7:0] & 8'h77);
            rd_chk(8'h36, v[15:8]);
            rd_chk(8'h37, v[23:16]);
            fork
                srfc_supply_model_inst.send(x[23:0]);
                wait_fb(i != 4, i == 4 ? 24'h0 : exp_fb(x[23:0], {v[2:0], v[15:8], v[23:16]},
                    v[6:4]));
            join
            rd_chk(8'h3b, x[23:16]);
            rd_chk(8'h3c, x[15:8]);
            rd_chk(8'h3d, x[7:0]);
            wr_reg(8'h3b, ~x[23:16]);
            rd_chk(8'h3b, x[23:16]);
        end
        $display("test measurement and feedback done");
        conclude();
    end
endmodule // supply_ripple_feedback_ctrl_tb_top
`default_nettype wire
